// ### iex_addr_por.v
// Reset, standby, address decode and input change detection of the expander.
// Assumes SCL, SDA, pins and supply monitor are asynchronous to core_clk;
// SCL runs far slower than core_clk so every edge is seen.
`timescale 1ns/1ps
`include "iex_regs.vh"

module iex_addr_por (
  // Clock and reset
  input  wire core_clk,
  input  wire nrst,
  // Supply monitor and reset pin
  input  wire supply_low,
  input  wire rst_pin_n,
  // Two-wire bus
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe,
  // Address-select pins
  input  wire addr_sel_low_pin,
  input  wire addr_sel_high_pin,
  // Input ports
  input  wire in_port_2,
  input  wire in_port_3,
  input  wire in_port_4,
  input  wire in_port_5,
  // Output ports
  output reg  out_port_0,
  output reg  out_port_1,
  output reg  out_port_6,
  output reg  out_port_7,
  // Pullup enables
  output wire pullup_en_2_3,
  output wire pullup_en_4_5,
  // Status
  output reg  int_n,
  output wire standby,
  output reg  [3:0] trans_flags,
  output reg  [3:0] int_mask
);

  // Two-flop synchronisers
  reg  [9:0] sync1;
  reg  [9:0] sync2;
  wire [9:0] raw_in = {in_port_5, in_port_4, in_port_3, in_port_2, addr_sel_low_pin,
                       addr_sel_high_pin, sda_in, scl_in, rst_pin_n, supply_low};

  always @(posedge core_clk) begin
    if (!nrst) begin
      sync1 <= `IEX_SYNC_RST;
      sync2 <= `IEX_SYNC_RST;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire       por_s   = sync2[0];
  wire       rpin_s  = sync2[1];
  wire       scl_s   = sync2[2];
  wire       sda_s   = sync2[3];
  wire       adhi_s  = sync2[4];
  wire       adlo_s  = sync2[5];
  wire [3:0] in_s    = sync2[9:6];

  wire rst = !nrst || por_s;

  // Line history for edge and condition detection
  reg scl_d;
  reg sda_d;
  always @(posedge core_clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c  = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c   = scl_s && scl_d && !sda_d && sda_s;

  // Serial interface state
  reg       busy;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg       first_byte;
  reg       byte_was_addr;
  reg       addressed;
  reg       rd;
  reg       ack_req;
  reg       ack_hi;
  reg       seen_first;
  reg [1:0] hi_cls;
  reg [1:0] lo_cls;

  wire [7:0] next_shift = {shift[6:0], sda_s};

  // Live pin classes in this transmission
  wire [1:0] cls_live [0:1];
  wire [1:0] pin_s = {adhi_s, adlo_s};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cls
      iex_pin_class u_cls (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (start_c),
        .busy     (busy),
        .pin      (pin_s[g]),
        .scl      (scl_s),
        .sda      (sda_s),
        .cls      (cls_live[g])
      );
    end
  endgenerate

  // Effective classes: level-only until the first transmission
  wire [1:0] lo_eff = seen_first ? lo_cls : (adlo_s ? `IEX_CLS_VDD : `IEX_CLS_GND);
  wire [1:0] hi_eff = seen_first ? hi_cls : (adhi_s ? `IEX_CLS_VDD : `IEX_CLS_GND);

  // Address codes of the classes seen in this transmission
  reg [1:0] hi_code;
  reg [1:0] lo_code;
  always @* begin
    case (cls_live[1])
      `IEX_CLS_SCL: hi_code = `IEX_HI_SCL;
      `IEX_CLS_SDA: hi_code = `IEX_HI_SDA;
      `IEX_CLS_GND: hi_code = `IEX_HI_GND;
      default:      hi_code = `IEX_HI_VDD;
    endcase
    case (cls_live[0])
      `IEX_CLS_GND: lo_code = `IEX_LO_GND;
      `IEX_CLS_VDD: lo_code = `IEX_LO_VDD;
      `IEX_CLS_SCL: lo_code = `IEX_LO_SCL;
      default:      lo_code = `IEX_LO_SDA;
    endcase
  end

  wire [6:0] my_addr   = {`IEX_ADDR_TOP, hi_code, lo_code};
  wire       addr_hit  = next_shift[7:1] == my_addr;

  // Acknowledge clock high with our acknowledge driven
  wire ack_edge    = scl_rise && bit_cnt == `IEX_BIT_ACK && sda_oe;
  wire access_ack  = ack_edge && byte_was_addr;
  wire write_ack   = ack_edge && !byte_was_addr;

  always @(posedge core_clk) begin
    if (rst) begin
      busy          <= 1'b0;
      bit_cnt       <= 4'h0;
      shift         <= 8'h00;
      first_byte    <= 1'b0;
      byte_was_addr <= 1'b0;
      addressed     <= 1'b0;
      rd            <= 1'b0;
      ack_req       <= 1'b0;
      ack_hi        <= 1'b0;
      sda_oe        <= 1'b0;
      seen_first    <= 1'b0;
      hi_cls        <= `IEX_CLS_GND;
      lo_cls        <= `IEX_CLS_GND;
    end else if (!rpin_s || stop_c) begin
      busy      <= 1'b0;
      bit_cnt   <= 4'h0;
      addressed <= 1'b0;
      ack_req   <= 1'b0;
      ack_hi    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start_c) begin
      busy       <= 1'b1;
      bit_cnt    <= 4'h0;
      first_byte <= 1'b1;
      addressed  <= 1'b0;
      ack_hi     <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (busy) begin
      if (scl_rise && bit_cnt != `IEX_BIT_ACK) begin
        shift   <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == `IEX_BIT_LAST) begin
          byte_was_addr <= first_byte;
          if (first_byte) begin
            first_byte <= 1'b0;
            addressed  <= addr_hit;
            rd         <= next_shift[0];
            ack_req    <= addr_hit;
            hi_cls     <= cls_live[1];
            lo_cls     <= cls_live[0];
            seen_first <= 1'b1;
          end else begin
            ack_req <= addressed && !rd;
          end
        end
      end else if (scl_rise) begin
        ack_hi <= 1'b1;
      end else if (scl_fall && bit_cnt == `IEX_BIT_ACK) begin
        if (!ack_hi) begin
          sda_oe <= ack_req;
        end else begin
          sda_oe  <= 1'b0;
          ack_hi  <= 1'b0;
          bit_cnt <= 4'h0;
        end
      end
    end
  end

  assign sda_out = 1'b0;
  assign standby = !busy;

  // Pullups and output defaults follow the effective classes
  wire lo_on = lo_eff != `IEX_CLS_GND;
  wire hi_on = hi_eff != `IEX_CLS_GND;
  assign pullup_en_2_3 = lo_on;
  assign pullup_en_4_5 = hi_on;

  // Outputs and mask; defaults track the pins until the first write
  localparam [7:0] mask_rst = `IEX_MASK_RST;
  reg out_written;
  always @(posedge core_clk) begin
    if (rst) begin
      out_written <= 1'b0;
      int_mask    <= mask_rst[`IEX_MASK_HI:`IEX_MASK_LO];
      out_port_0  <= 1'b0;
      out_port_1  <= 1'b0;
      out_port_6  <= 1'b0;
      out_port_7  <= 1'b0;
    end else if (write_ack) begin
      out_written <= 1'b1;
      int_mask    <= shift[`IEX_MASK_HI:`IEX_MASK_LO];
      out_port_0  <= shift[0];
      out_port_1  <= shift[1];
      out_port_6  <= shift[6];
      out_port_7  <= shift[7];
    end else if (!out_written) begin
      out_port_0  <= lo_on;
      out_port_1  <= lo_on;
      out_port_6  <= hi_on;
      out_port_7  <= hi_on;
    end
  end

  // Change detection, untouched by the reset pin
  reg  [3:0] snapshot;
  wire [3:0] mismatch = in_s ^ snapshot;

  always @(posedge core_clk) begin
    if (rst) begin
      snapshot    <= 4'h0;
      trans_flags <= 4'h0;
      int_n       <= 1'b1;
    end else begin
      if (access_ack) begin
        // Snapshot takes the live value, so a change in this cycle sets no flag
        snapshot    <= in_s;
        trans_flags <= 4'h0;
        int_n       <= 1'b1;
      end else begin
        trans_flags <= trans_flags | mismatch;
        int_n       <= ~|((trans_flags | mismatch) & int_mask);
      end
    end
  end

endmodule

// ### iex_master.sv
// Bus master model: SCL of 400 ns period, pulls SDA low when sda_lo.
// Assumes SDA has a pull-up; changes land on falling clk edges.
`timescale 1ns/1ps
module iex_master (
  // Clock
  input  wire clk,
  // Bus
  input  wire sda,
  output reg  scl = 1'b1,
  output reg  sda_lo = 1'b0
);
  task q;
    repeat (2) @(negedge clk);
  endtask
  task start;
    sda_lo = 1'b1;
    q;
    q;
    scl = 1'b0;
    q;
  endtask
  // Eight bits add the ack slot; ack is SDA low in it
  task send(input [7:0] b, input integer n, output reg ack);
    integer i;
    for (i = 0; i < (n == 8 ? 9 : n); i = i + 1) begin
      sda_lo = (i < 8) ? ~b[7 - i] : 1'b0;
      q;
      scl = 1'b1;
      q;
      ack = ~sda;
      q;
      scl = 1'b0;
      q;
    end
  endtask
  task stop;
    sda_lo = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_lo = 1'b0;
    q;
    q;
  endtask
endmodule

// ### iex_pin_class.v
// Classifier for one address-select pin against SDA, SCL and fixed levels.
// Assumes all inputs are already synchronised to core_clk.
`timescale 1ns/1ps
`include "iex_regs.vh"

module iex_pin_class (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Transmission framing
  input  wire       start,
  input  wire       busy,
  // Sampled lines
  input  wire       pin,
  input  wire       scl,
  input  wire       sda,
  // Class of the pin in this transmission
  output wire [1:0] cls
);

  reg ne_scl;
  reg ne_sda;
  reg seen_hi;

  always @(posedge core_clk) begin
    if (rst || start) begin
      ne_scl  <= 1'b0;
      ne_sda  <= 1'b0;
      seen_hi <= 1'b0;
    end else if (busy) begin
      if (pin != scl) ne_scl <= 1'b1;
      if (pin != sda) ne_sda <= 1'b1;
      if (pin) seen_hi <= 1'b1;
    end
  end

  // Following a line means tied to it; otherwise a fixed level
  assign cls = !ne_scl ? `IEX_CLS_SCL :
               !ne_sda ? `IEX_CLS_SDA :
               seen_hi ? `IEX_CLS_VDD : `IEX_CLS_GND;

endmodule

// ### iex_props.sv
// Assertions on the expander top ports.
// Assumes a bind onto iex_addr_por.
`timescale 1ns/1ps
module iex_props (
  // Clock and resets
  input wire       core_clk,
  input wire       nrst,
  input wire       supply_low,
  input wire       rst_pin_n,
  // Status
  input wire       sda_oe,
  input wire       int_n,
  input wire       standby,
  input wire [3:0] trans_flags,
  input wire [3:0] int_mask
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_por_defaults: assert property (
    supply_low [*3] |=> int_mask == 4'hF && trans_flags == 4'h0 && int_n)
    else $error("defaults not restored");
  a_pin_idle: assert property (
    !rst_pin_n [*3] |=> standby && !sda_oe)
    else $error("bus not idle in pin reset");
  a_int_kept: assert property (
    !rst_pin_n [*3] ##0 (!int_n && !supply_low && !$past(supply_low)) |=> !int_n)
    else $error("pin reset cleared interrupt");
  a_int_cause: assert property (
    $fell(int_n) |-> |(trans_flags & int_mask))
    else $error("interrupt without masked flag");
  a_flag_clear: assert property (
    |($past(trans_flags) & ~trans_flags) |->
      sda_oe || $past(supply_low, 2) || $past(supply_low, 3))
    else $error("flag cleared outside ack");
  a_int_release: assert property (
    $rose(int_n) |-> sda_oe || $past(supply_low, 2) || $past(supply_low, 3))
    else $error("interrupt released outside ack");
  a_ack_busy: assert property (
    sda_oe |-> !standby)
    else $error("ack while in standby");
  a_ack_hold: assert property (
    $rose(sda_oe) && rst_pin_n |-> sda_oe [*4])
    else $error("ack too short");
endmodule

// ### iex_regs.vh
// Constants for the port expander address, reset and change-detect block.
// Assumes includes by bare name from the design files in this folder.
//
// Behaviour
// - Supply below power-on threshold holds everything in reset and restores defaults.
// - Reset pin aborts any transaction and returns the interface to idle.
// - Reset pin leaves interrupt output and transition flags untouched.
// - Idle serial interface means standby, left again when bus activity starts.
// - Slave address is re-decoded on every bus transmission, to anyone.
// - Each address-select pin is classified as SDA, SCL, supply or ground.
// - Address is 110 plus high-pin code and low-pin code per fixed tables.
// - Before the first transmission pins decode as high or low only.
// - Low select pin sets pullups of inputs 2,3 and defaults of outputs 0,1.
// - High select pin sets pullups of inputs 4,5 and defaults of outputs 6,7.
// - High, SDA or SCL enables pullups and defaults high; ground disables, low.
// - First transmission on the bus corrects pullup and default configuration.
// - Four inputs are watched against a snapshot from the last access.
// - Snapshot mismatch sets that input's flag and asserts the interrupt if its mask bit is set.
// - Acknowledge of each access latches snapshot and clears old flags.
// - Mask starts as 0x3C, flags start cleared.
`ifndef IEX_REGS_VH
`define IEX_REGS_VH

// Fixed upper address bits
`define IEX_ADDR_TOP     3'h6
// Pin classes
`define IEX_CLS_GND      2'h0
`define IEX_CLS_VDD      2'h1
`define IEX_CLS_SCL      2'h2
`define IEX_CLS_SDA      2'h3
// Address codes of the high select pin
`define IEX_HI_SCL       2'h0
`define IEX_HI_SDA       2'h1
`define IEX_HI_GND       2'h2
`define IEX_HI_VDD       2'h3
// Address codes of the low select pin
`define IEX_LO_GND       2'h0
`define IEX_LO_VDD       2'h1
`define IEX_LO_SCL       2'h2
`define IEX_LO_SDA       2'h3
// Written byte layout and mask reset value
`define IEX_MASK_RST     8'h3C
`define IEX_MASK_HI      5
`define IEX_MASK_LO      2
// Bits per byte before the acknowledge slot
`define IEX_BIT_ACK      4'h8
`define IEX_BIT_LAST     4'h7
// Synchroniser reset: {in[3:0], ad_lo, ad_hi, sda, scl, rst_pin_n, supply_low}
`define IEX_SYNC_RST     10'h00E

`endif

// ### tb_iex_addr_por.sv
// Bench of the expander address, reset and change-detect block.
// Assumes pin ties coded 0 ground, 1 supply, 2 SCL, 3 SDA.
`timescale 1ns/1ps
module tb_iex_addr_por;
  reg        core_clk = 1'b0;
  reg        nrst = 1'b0;
  reg        supply_low = 1'b0;
  reg        rst_pin_n = 1'b1;
  reg  [1:0] sel_lo = 2'h2;
  reg  [1:0] sel_hi = 2'h0;
  reg  [3:0] din = 4'h0;
  reg        ack;
  reg        dack;
  integer    n_errors = 0;
  integer    total_checks = 0;
  integer    h;
  integer    l;
  wire       scl, m_lo, sda_oe, sda_out, pu23, pu45, int_n, standby;
  wire [3:0] outs, flags, mask;
  wire       sda = ~(m_lo | (sda_oe & ~sda_out));
  wire       ad_lo = sel_lo[1] ? (sel_lo[0] ? sda : scl) : sel_lo[0];
  wire       ad_hi = sel_hi[1] ? (sel_hi[0] ? sda : scl) : sel_hi[0];
  wire [7:0] adr = {3'h6, sel_hi ^ 2'h2, sel_lo, 1'b0};
  always #25 core_clk = ~core_clk;
  iex_master iex_master_i (.clk(core_clk), .sda, .scl, .sda_lo(m_lo));
  iex_addr_por iex_addr_por_i (.core_clk, .nrst, .supply_low, .rst_pin_n,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .addr_sel_low_pin(ad_lo), .addr_sel_high_pin(ad_hi),
    .in_port_2(din[0]), .in_port_3(din[1]), .in_port_4(din[2]), .in_port_5(din[3]),
    .out_port_0(outs[0]), .out_port_1(outs[1]), .out_port_6(outs[2]),
    .out_port_7(outs[3]), .pullup_en_2_3(pu23), .pullup_en_4_5(pu45),
    .int_n, .standby, .trans_flags(flags), .int_mask(mask));
  task chk(input string nm, input [7:0] s, input [7:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task xfer(input [7:0] a, input [7:0] d);
    iex_master_i.start;
    iex_master_i.send(a, 8, ack);
    iex_master_i.send(d, 8, dack);
    iex_master_i.stop;
    wc(4);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    wc(10);
    nrst = 1'b1;
    wc(8);
    chk("pu23", pu23, 8'h01);
    chk("pu45", pu45, 8'h00);
    chk("outs", outs, 8'h03);
    chk("mask", mask, 8'h0F);
    chk("flags", flags, 8'h00);
    chk("int", int_n, 8'h01);
    chk("stby", standby, 8'h01);
    $display("test power-up done");
    for (h = 0; h < 4; h = h + 1) begin
      for (l = 0; l < 4; l = l + 1) begin
        sel_hi = h[1:0];
        sel_lo = l[1:0];
        wc(2);
        xfer(adr ^ 8'h02, 8'h00);
        chk("ack", ack, 8'h00);
        chk("dack", dack, 8'h00);
        chk("pu23", pu23, sel_lo != 2'h0);
        chk("pu45", pu45, sel_hi != 2'h0);
        xfer(adr, {sel_lo, 4'hF, sel_hi});
        chk("ack", ack, 8'h01);
        chk("dack", dack, 8'h01);
        chk("outs", outs, {sel_lo, sel_hi});
      end
    end
    $display("test address map done");
    din = 4'h2;
    wc(6);
    chk("flags", flags, 8'h02);
    chk("int", int_n, 8'h00);
    rst_pin_n = 1'b0;
    wc(6);
    rst_pin_n = 1'b1;
    wc(4);
    chk("flags", flags, 8'h02);
    chk("int", int_n, 8'h00);
    xfer(adr, 8'h00);
    chk("flags", flags, 8'h00);
    chk("mask", mask, 8'h00);
    chk("int", int_n, 8'h01);
    din = 4'h0;
    wc(6);
    chk("flags", flags, 8'h02);
    chk("int", int_n, 8'h01);
    iex_master_i.start;
    iex_master_i.send(adr | 8'h01, 8, ack);
    iex_master_i.stop;
    wc(4);
    chk("ack", ack, 8'h01);
    chk("flags", flags, 8'h00);
    chk("int", int_n, 8'h01);
    $display("test change detect done");
    iex_master_i.start;
    chk("stby", standby, 8'h00);
    iex_master_i.send(adr, 4, ack);
    rst_pin_n = 1'b0;
    wc(4);
    chk("stby", standby, 8'h01);
    rst_pin_n = 1'b1;
    iex_master_i.stop;
    xfer(adr, 8'h00);
    chk("ack", ack, 8'h01);
    $display("test abort done");
    supply_low = 1'b1;
    wc(4);
    chk("mask", mask, 8'h0F);
    chk("flags", flags, 8'h00);
    supply_low = 1'b0;
    wc(8);
    chk("outs", outs, 8'h0F);
    $display("test power-on reset done");
    print_verdict;
  end
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule
bind iex_addr_por iex_props iex_props_i (.core_clk, .nrst, .supply_low, .rst_pin_n,
  .sda_oe, .int_n, .standby, .trans_flags, .int_mask);
